// ### smbus_flags_pkg.sv
// Constants, register map and state type for the SMBus flag update block.
// Assumes a 250 MHz system clock and a 32-bit APB register bus.
package smbus_flags_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] SADDR_OFS = 8'h08;

  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int unsigned BIT_OWNER = 7;
  localparam int unsigned BIT_TXDIR = 6;
  localparam int unsigned BIT_BEGIN = 5;
  localparam int unsigned BIT_HALT = 4;
  localparam int unsigned BIT_ACK_RESPONSE_NEEDED = 3;
  localparam int unsigned BIT_ARB = 2;
  localparam int unsigned BIT_ACK = 1;
  localparam int unsigned BIT_EVT = 0;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] SADDR_RST = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_CLK_NS = 4;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / SYS_CLK_NS;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'h9;

  typedef enum logic [3:0] {
    M_IDLE,
    M_PREP,
    M_SETUP,
    M_START,
    M_LOW,
    M_HIGH,
    M_STOP_LOW,
    M_STOP_HIGH,
    M_STOP_END
  } master_state_t;

endpackage

// ### smbus_status_flag_update.sv
// SMBus control/status flag update logic with a small bit engine and APB slave.
// Assumes SCL/SDA are open-drain pins resolved outside; pins arrive asynchronously.
// Contract
// - Byte-event flag is set by hardware only; only software clears it.
// - While byte-event flag is set and the bus is busy, SCL is held low, stalling the bus.
// - Bus owner set on generated START, cleared on generated STOP or arbitration loss.
// - Transmit direction set on generated START or data written before a frame.
// - Transmit direction cleared on detected START, arbitration loss, or no data write.
// - Begin request set when a START and a matching slave address byte are received.
// - Halt request set when STOP is seen while addressed as slave.
// - Halt request set when arbitration is lost to a detected STOP.
// - Halt request cleared once the pending STOP has been generated.
// - Ack-needed set after a received byte, cleared after every acknowledge cycle.
// - Arbitration lost on unwanted repeated START as owner with begin request low.
// - Arbitration lost when SCL is low while making STOP or repeated START.
// - Arbitration lost when SDA is low while sending a one, ack excluded.
// - Arbitration lost flag cleared whenever software clears the byte-event flag.
// - Acknowledge flag loads one for a low ack bit, zero for high.
// - Byte-event flag set after a generated START and on arbitration loss.
// - Byte-event flag set after a sent byte with its ack, or a received byte.
// - Byte-event flag set on START followed by a matching slave address.
// - Byte-event flag set when a STOP is received while addressed as slave.
// - With both begin and halt requests set, STOP goes out before START.
// - Receive event comes before the ack cycle, transmit event after it.
`timescale 1ns/1ps
module smbus_status_flag_update
  import smbus_flags_pkg::*;
#(
  parameter int HALF_CYCLES = SCL_HALF_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  output logic IRQ
);

  localparam int TW = $clog2(HALF_CYCLES + 1);
  localparam logic [TW-1:0] TICK_AT = TW'(HALF_CYCLES - 1);

  // Start/stop self-detection must land inside one half period
  if (HALF_CYCLES < 8)
  begin : g_half_check
    $error("HALF_CYCLES must be at least 8");
  end

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic owner;
  logic transmit_direction_flag;
  logic begin_request_flag;
  logic halt_request_flag;
  logic ack_response_needed;
  logic arbitration_fail_flag;
  logic ack;
  logic evt;
  logic [7:0] shift_byte_reg;
  logic [7:0] slave_addr;
  logic data_written;
  logic addressed;
  logic addr_phase;
  logic busy;
  logic [3:0] bcnt;
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic sda_low;
  master_state_t ms;
  master_state_t next_ms;
  logic [TW-1:0] tcnt;

  // ----------------------------------------
  // Bus event decode
  // ----------------------------------------
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
  wire tick = (tcnt == TICK_AT);
  wire own_start = (ms == M_START);
  wire own_stop = (ms == M_STOP_END);
  wire ext_start = start_det & ~own_start;
  wire ext_stop = stop_det & ~own_stop;
  wire active = owner | addressed;
  wire data_slot = (bcnt < DATA_BITS);
  wire byte_done = scl_fall & (bcnt == DATA_BITS);
  wire ack_done = scl_fall & (bcnt == FRAME_BITS);
  wire ack_sampled = scl_rise & (bcnt == DATA_BITS);
  wire start_gen = own_start & tick;
  wire stop_gen = own_stop & tick;

  wire arb_bit = owner & transmit_direction_flag & scl_rise & data_slot
    & shift_byte_reg[7] & ~sda_s;
  wire arb_scl = tick & ((ms == M_SETUP) | (ms == M_STOP_HIGH)) & ~scl_s;
  wire arb_rstart = ext_start & owner & ~begin_request_flag;
  wire arb_stop = ext_stop & owner;
  wire arb_lost = arb_bit | arb_scl | arb_rstart | arb_stop;

  wire addr_match = byte_done & addr_phase & ~owner
    & (shift_byte_reg[7:1] == slave_addr[7:1]);
  wire rx_byte = byte_done & active & ~transmit_direction_flag;
  wire tx_byte = ack_done & active & transmit_direction_flag;
  wire slave_stop = ext_stop & addressed;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire wr = PSEL & PENABLE & PWRITE;
  wire ctrl_wr = wr & is_reg(PADDR, CTRL_OFS);
  wire data_wr = wr & is_reg(PADDR, DATA_OFS);
  wire saddr_wr = wr & is_reg(PADDR, SADDR_OFS);
  wire hit = is_reg(PADDR, CTRL_OFS) | is_reg(PADDR, DATA_OFS)
    | is_reg(PADDR, SADDR_OFS);
  wire sw_evt_clear = ctrl_wr & ~PWDATA[BIT_EVT] & evt;
  // Clearing the event marks the boundary before the next frame
  wire frame_start = sw_evt_clear;

  wire [7:0] ctrl_rd = {owner, transmit_direction_flag, begin_request_flag,
    halt_request_flag, ack_response_needed, arbitration_fail_flag, ack, evt};
  wire [7:0] rd_byte = is_reg(PADDR, CTRL_OFS) ? ctrl_rd
    : is_reg(PADDR, DATA_OFS) ? shift_byte_reg
    : is_reg(PADDR, SADDR_OFS) ? slave_addr : 8'h00;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

  // ----------------------------------------
  // Flag next values
  // ----------------------------------------
  wire next_evt = start_gen | arb_lost
    | tx_byte | rx_byte
    | addr_match
    | slave_stop
    | (evt & ~sw_evt_clear);
  wire next_owner = start_gen | (owner & ~stop_gen & ~arb_lost);
  wire next_arb = arb_lost | (arbitration_fail_flag & ~sw_evt_clear);
  wire next_ack_response_needed = rx_byte | addr_match | (ack_response_needed & ~ack_done);
  wire next_begin = addr_match
    | (ctrl_wr ? PWDATA[BIT_BEGIN] : begin_request_flag);
  wire next_halt = slave_stop | arb_stop
    | (ctrl_wr ? PWDATA[BIT_HALT] : (halt_request_flag & ~stop_gen));

  logic next_txdir;
  assign next_txdir = start_gen ? 1'b1
    : (ext_start | arb_lost) ? 1'b0
    : frame_start ? data_written
    : transmit_direction_flag;

  logic next_ack;
  assign next_ack = (ack_sampled & active & transmit_direction_flag) ? ~sda_s
    : ctrl_wr ? PWDATA[BIT_ACK] : ack;

  // ----------------------------------------
  // Master sequencer
  // ----------------------------------------
  always_comb
  begin
    next_ms = ms;
    case (ms)
      M_IDLE:
        if (begin_request_flag & ~halt_request_flag & ~busy & ~evt)
          next_ms = M_SETUP;
      M_PREP:
        if (tick)
          next_ms = M_SETUP;
      M_SETUP:
        if (tick)
          next_ms = arb_scl ? M_IDLE : M_START;
      M_START:
        if (tick)
          next_ms = M_LOW;
      M_LOW:
        if (!evt)
        begin
          if (halt_request_flag)
            next_ms = M_STOP_LOW;
          else if (begin_request_flag && bcnt == 4'h0)
            next_ms = M_PREP;
          else if (tick)
            next_ms = M_HIGH;
        end
      M_HIGH:
        if (tick)
          next_ms = M_LOW;
      M_STOP_LOW:
        if (tick)
          next_ms = M_STOP_HIGH;
      M_STOP_HIGH:
        if (tick)
          next_ms = arb_scl ? M_IDLE : M_STOP_END;
      M_STOP_END:
        if (tick)
          next_ms = M_IDLE;
      default:
        next_ms = M_IDLE;
    endcase
    if (arb_lost)
      next_ms = M_IDLE;
  end

  // Timer restarts on each state change; a stretched SCL high phase waits
  wire tcnt_clr = (next_ms != ms) | (ms == M_IDLE) | ((ms == M_HIGH) & ~scl_s)
    | ((ms == M_LOW) & evt) | tick;

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  wire m_scl_low = (ms == M_PREP) | (ms == M_LOW) | (ms == M_STOP_LOW);
  wire m_sda_force = (ms == M_START) | (ms == M_STOP_LOW) | (ms == M_STOP_HIGH);
  wire m_sda_free = (ms == M_PREP) | (ms == M_SETUP) | (ms == M_STOP_END);
  // Only hold the clock inside a frame, never on an idle bus after STOP
  wire scl_hold = (evt & busy) | m_scl_low;
  wire next_sda_low = active & ((data_slot & transmit_direction_flag & ~shift_byte_reg[7])
    | ((bcnt == DATA_BITS) & ~transmit_direction_flag & ack));
  wire sda_drive = m_sda_force | (~m_sda_free & sda_low);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // ----------------------------------------
  // Control/status flags
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      owner <= 1'b0;
      transmit_direction_flag <= 1'b0;
      begin_request_flag <= 1'b0;
      halt_request_flag <= 1'b0;
      ack_response_needed <= 1'b0;
      arbitration_fail_flag <= 1'b0;
      ack <= 1'b0;
      evt <= 1'b0;
    end
    else
    begin
      owner <= next_owner;
      transmit_direction_flag <= next_txdir;
      begin_request_flag <= next_begin;
      halt_request_flag <= next_halt;
      ack_response_needed <= next_ack_response_needed;
      arbitration_fail_flag <= next_arb;
      ack <= next_ack;
      evt <= next_evt;
    end
  end

  // ----------------------------------------
  // Frame tracking and data
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      shift_byte_reg <= DATA_RST;
      slave_addr <= SADDR_RST;
      data_written <= 1'b0;
      addressed <= 1'b0;
      addr_phase <= 1'b0;
      busy <= 1'b0;
      bcnt <= 4'h0;
    end
    else
    begin
      // Bus is sampled even while sending, so lost arbitration keeps live data
      if (data_wr)
        shift_byte_reg <= PWDATA[7:0];
      else if (scl_rise && data_slot)
        shift_byte_reg <= {shift_byte_reg[6:0], sda_s};
      if (saddr_wr)
        slave_addr <= PWDATA[7:0];
      data_written <= data_wr | (data_written & ~frame_start);
      addressed <= addr_match | (addressed & ~ext_start & ~ext_stop);
      addr_phase <= ext_start | (addr_phase & ~byte_done);
      busy <= start_det | (busy & ~stop_det);
      if (start_det || stop_det || ack_done)
        bcnt <= 4'h0;
      else if (scl_rise && bcnt < FRAME_BITS)
        bcnt <= bcnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Sequencer, pins and bus read data
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ms <= M_IDLE;
      tcnt <= '0;
      sda_low <= 1'b0;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
      IRQ <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      ms <= next_ms;
      tcnt <= tcnt_clr ? '0 : tcnt + TW'(1);
      // Data line only changes while the clock is low
      if (!scl_s)
        sda_low <= next_sda_low;
      SCL_OE_N <= ~scl_hold;
      SDA_OE_N <= ~sda_drive;
      IRQ <= next_evt;
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= {24'h00_0000, rd_byte};
    end
  end

endmodule

// ### smbus_status_flag_update_properties.sv
// Properties on the ports of the SMBus flag block.
// Assumes it is bound onto the block with its HALF_CYCLES value.
`timescale 1ns/1ps
module smbus_status_flag_update_properties
  import smbus_flags_pkg::*;
#(
  parameter int HALF_CYCLES = 16
)
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_N,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N,
  input wire logic IRQ
);
  localparam int EVT_MAX = 2 * HALF_CYCLES + 8;
  wire evt_clr = PSEL && PENABLE && PWRITE && PADDR == CTRL_OFS && !PWDATA[BIT_EVT];
  wire mapped = PADDR == CTRL_OFS || PADDR == DATA_OFS || PADDR == SADDR_OFS;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence start_gen;
    SCL_OE_N && SDA_OE_N ##1 SCL_OE_N && !SDA_OE_N;
  endsequence
  sequence stop_gen;
    SCL_OE_N && !SDA_OE_N ##1 SCL_OE_N && SDA_OE_N;
  endsequence
  a_evt_self_clear: assert property ($fell(IRQ) |-> $past(evt_clr))
    else $error("event dropped without software clear");
  a_irq_holds: assert property (IRQ && !evt_clr |=> IRQ)
    else $error("interrupt dropped early");
  a_scl_held_low: assert property (IRQ && !SCL_OE_N |=> !SCL_OE_N || !IRQ)
    else $error("SCL released while event set");
  a_start_event: assert property (start_gen |-> ##[1:EVT_MAX] IRQ)
    else $error("no event after START");
  a_stop_bus_free: assert property (stop_gen |=> (SCL_OE_N && SDA_OE_N) [*8])
    else $error("bus not free after STOP");
  a_slverr_map: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("slave error does not match map");
  a_open_drain: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
    else $error("pin driven high");
  a_rdata_upper: assert property (PRDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule

// ### smbus_bus_partner.sv
// Slave on the SMBus wires that acknowledges every byte and keeps the bits seen.
// Assumes both wires resolved with pull-ups by the bench.
`timescale 1ns/1ps
module smbus_bus_partner
(
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n,
  output logic [7:0] rx
);
  int n = -1;
  initial sda_oe_n = 1'b1;
  initial rx = 8'h00;
  always @(negedge sda) if (scl) n = 0;
  always @(posedge sda) if (scl) n = -1;
  always @(posedge scl) if (n > 0 && n < 9) rx = {rx[6:0], sda};
  // Ninth clock is the ack slot; released otherwise so the pull-up wins
  always @(negedge scl)
  begin
    if (n >= 0) n = (n == 9) ? 1 : n + 1;
    sda_oe_n = (n != 9);
  end
endmodule

// ### test_smbus_status_flag_update.sv
// Bench: APB tasks run reset, START, one sent byte and STOP.
// Assumes the partner slave and the properties checker in this folder.
`timescale 1ns/1ps
module test_smbus_status_flag_update;
  import smbus_flags_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl_o;
  logic scl_oe_n;
  logic sda_o;
  logic sda_oe_n;
  logic irq;
  logic p_oe_n;
  logic [7:0] p_rx;
  logic [31:0] q;
  logic err;
  int fails = 0;
  int cmp_count = 0;
  wire scl = scl_oe_n | scl_o;
  wire sda = (sda_oe_n | sda_o) & p_oe_n;
  initial forever #2 clk = ~clk;
  smbus_status_flag_update #(.HALF_CYCLES(16)) i_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .IRQ(irq));
  smbus_bus_partner i_slave (.scl(scl), .sda(sda), .sda_oe_n(p_oe_n), .rx(p_rx));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wirq();
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk);
    chk("irq", 32'h1, irq);
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, CTRL_OFS, 0);
    chk("ctrl", 0, q);
    chk("irq", 0, irq);
    bus(0, 8'h0C, 0);
    chk("slverr", 32'h1, err);
    chk("unmapped", 0, q);
    $display("Test reset done");
    bus(1, CTRL_OFS, 32'h20);
    wirq();
    bus(0, CTRL_OFS, 0);
    chk("ctrl", 32'hE1, q);
    chk("scl", 0, scl);
    $display("Test start done");
    bus(1, DATA_OFS, 32'hA6);
    bus(1, CTRL_OFS, 0);
    wirq();
    bus(0, CTRL_OFS, 0);
    chk("ctrl", 32'hC3, q);
    chk("wire byte", 32'hA6, p_rx);
    $display("Test byte done");
    bus(1, CTRL_OFS, 32'h10);
    for (int i = 0; i < 60 && q[BIT_OWNER] !== 1'b0; i++) bus(0, CTRL_OFS, 0);
    chk("ctrl", 0, q);
    bus(1, CTRL_OFS, 32'h02);
    bus(0, CTRL_OFS, 0);
    chk("ack", 32'h02, q);
    bus(1, CTRL_OFS, 32'h01);
    bus(0, CTRL_OFS, 0);
    chk("ctrl", 0, q);
    $display("Test stop done");
    summarize();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
bind smbus_status_flag_update smbus_status_flag_update_properties #(.HALF_CYCLES(HALF_CYCLES)) i_props (.*);
